// File: rtl/esl_pkg.sv
// package for the external interrupt status logic: offsets, field
// positions, reset values and widths shared by the design files.
// assumes a plain register port with a bank-select address bit.
package esl_pkg;

  // address: bit 8 picks the second base block, bits 7:0 the offset
  localparam int ADDR_W = 9;
  localparam int BLK_SEL_BIT = 8;
  localparam int DATA_W = 32;
  localparam int EXT_N = 8;
  localparam int ACPI_N = 2;

  // first base block (status side)
  localparam logic [8:0] OFF_TOP_STAT = 9'h002;
  localparam logic [8:0] OFF_IRQ_MASK = 9'h00c;
  localparam logic [8:0] OFF_ACPI_MIRROR = 9'h020;
  localparam logic [8:0] OFF_ACPI_STAT = 9'h022;
  localparam logic [8:0] OFF_EXT_REG = 9'h024;
  // second base block (firmware interface side)
  localparam logic [8:0] OFF_THT_CTRL = 9'h100;
  localparam logic [8:0] OFF_CMD_PORT = 9'h106;
  localparam logic [8:0] OFF_SRC_EN = 9'h118;

  // field positions
  localparam int EXT_EN_LSB = 0;
  localparam int EXT_MIR_LSB = 8;
  localparam int EXT_STAT_LSB = 16;
  localparam int TOP_ACPI_BIT = 2;
  localparam int TOP_EXT_BIT = 10;
  localparam int THT_BIT = 4;
  localparam int THT_IRQ_EN_BIT = 8;
  localparam int ACPI_CMD_BIT = 0;
  localparam int ACPI_THT_BIT = 1;
  localparam int CMD_W = 8;

  // reset values
  localparam logic [7:0] EXT_EN_RST = 8'h00;
  localparam logic THT_IRQ_EN_RST = 1'b1;
  localparam logic [15:0] IRQ_MASK_RST = 16'h0404;
  localparam logic [7:0] CMD_RST = 8'h00;

endpackage

// File: rtl/esl_stat_if.sv
// interface between the register logic and a sticky status bank.
// assumes both ends share sys_clk and rst.
interface esl_stat_if #(
  parameter int W = 8
);
  logic [W-1:0] set;
  logic [W-1:0] clr;
  logic [W-1:0] stat;
  modport bank(input set, input clr, output stat);
  modport ctl(output set, output clr, input stat);
endinterface

// File: rtl/esl_stat_bank.sv
// sticky status bank: bits set by hardware, cleared by a read strobe.
// assumes set and clr are one-cycle terms computed in the same clock.
module esl_stat_bank
  import esl_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  esl_stat_if.bank st
);

  logic [W-1:0] stat_ff;
  logic [W-1:0] nxt_stat;

  ////////////////////////////////////////////////////////////////////
  // set beats clear so an event landing on the clearing read is kept
  always_comb begin
    nxt_stat = (stat_ff & ~st.clr) | st.set;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stat_ff <= '0;
    end else begin
      stat_ff <= nxt_stat;
    end
  end

  assign st.stat = stat_ff;

  ////////////////////////////////////////////////////////////////////
  set_wins_a: assert property (@(posedge sys_clk) disable iff (rst)
    (st.set != '0) |=> ((stat_ff & $past(st.set)) == $past(st.set)))
    else $error("a set event was lost");

endmodule

// File: rtl/esl_top.sv
// external interrupt status logic: enables, sticky status, mirrors,
// firmware-interface event sources and the summary interrupt output.
// assumes a plain register port, read data valid the cycle after.
module esl_top
  import esl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic [EXT_N-1:0] ext_int_in,
  output logic system_mgmt_interrupt
);

  ////////////////////////////////////////////////////////////////////
  // address match, used by every decode below
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  esl_stat_if #(.W(EXT_N)) ext_if ();
  esl_stat_if #(.W(ACPI_N)) acpi_if ();

  logic [EXT_N-1:0] ext_en_ff;
  logic [EXT_N-1:0] nxt_ext_en;
  logic tht_bit_ff;
  logic nxt_tht_bit;
  logic tht_irq_en_ff;
  logic nxt_tht_irq_en;
  logic [CMD_W-1:0] cmd_ff;
  logic [CMD_W-1:0] nxt_cmd;
  logic [15:0] mask_ff;
  logic [15:0] nxt_mask;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;
  logic irq_ff;
  logic nxt_irq;

  logic cmd_wr;
  logic tht_wr1;
  logic ext_summary;
  logic acpi_summary;
  logic [15:0] top_stat;
  logic [DATA_W-1:0] ext_word;

  ////////////////////////////////////////////////////////////////////
  // event sources
  assign cmd_wr = reg_wr && hit(reg_addr, OFF_CMD_PORT);
  // a write of 1 triggers each time, even if the bit already reads 1
  assign tht_wr1 = reg_wr && hit(reg_addr, OFF_THT_CTRL) &&
                   reg_wdata[THT_BIT];

  // sticky bank feeds: set terms and read-to-clear strobes
  always_comb begin
    ext_if.set = ext_int_in & ext_en_ff;
    ext_if.clr = '0;
    if (reg_rd && hit(reg_addr, OFF_EXT_REG)) begin
      ext_if.clr = '1;
    end
    acpi_if.set = '0;
    acpi_if.set[ACPI_CMD_BIT] = cmd_wr;
    acpi_if.set[ACPI_THT_BIT] = tht_wr1 && tht_irq_en_ff;
    acpi_if.clr = '0;
    if (reg_rd && hit(reg_addr, OFF_ACPI_STAT)) begin
      acpi_if.clr = '1;
    end
  end

  esl_stat_bank #(.W(EXT_N)) u_ext_bank (
    .sys_clk(sys_clk),
    .rst(rst),
    .st(ext_if.bank)
  );

  esl_stat_bank #(.W(ACPI_N)) u_acpi_bank (
    .sys_clk(sys_clk),
    .rst(rst),
    .st(acpi_if.bank)
  );

  ////////////////////////////////////////////////////////////////////
  // top-level view; clearing the second level drops these as well
  assign ext_summary = |(ext_if.stat & ext_en_ff);
  assign acpi_summary = |acpi_if.stat;
  always_comb begin
    top_stat = '0;
    top_stat[TOP_EXT_BIT] = ext_summary;
    top_stat[TOP_ACPI_BIT] = acpi_summary;
  end

  // external register image; reserved bits always read zero
  always_comb begin
    ext_word = '0;
    ext_word[EXT_EN_LSB +: EXT_N] = ext_en_ff;
    ext_word[EXT_MIR_LSB +: EXT_N] = ext_if.stat;
    ext_word[EXT_STAT_LSB +: EXT_N] = ext_if.stat;
  end

  ////////////////////////////////////////////////////////////////////
  // writable registers; reserved bits of a write are simply dropped
  always_comb begin
    nxt_ext_en = ext_en_ff;
    nxt_tht_bit = tht_bit_ff;
    nxt_tht_irq_en = tht_irq_en_ff;
    nxt_cmd = cmd_ff;
    nxt_mask = mask_ff;
    if (reg_wr) begin
      if (hit(reg_addr, OFF_EXT_REG)) begin
        nxt_ext_en = reg_wdata[EXT_EN_LSB +: EXT_N];
      end else if (hit(reg_addr, OFF_THT_CTRL)) begin
        nxt_tht_bit = reg_wdata[THT_BIT];
      end else if (hit(reg_addr, OFF_CMD_PORT)) begin
        nxt_cmd = reg_wdata[CMD_W-1:0];
      end else if (hit(reg_addr, OFF_SRC_EN)) begin
        nxt_tht_irq_en = reg_wdata[THT_IRQ_EN_BIT];
      end else if (hit(reg_addr, OFF_IRQ_MASK)) begin
        nxt_mask = reg_wdata[15:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ext_en_ff <= EXT_EN_RST;
      tht_bit_ff <= 1'b0;
      tht_irq_en_ff <= THT_IRQ_EN_RST;
      cmd_ff <= CMD_RST;
      mask_ff <= IRQ_MASK_RST;
    end else begin
      ext_en_ff <= nxt_ext_en;
      tht_bit_ff <= nxt_tht_bit;
      tht_irq_en_ff <= nxt_tht_irq_en;
      cmd_ff <= nxt_cmd;
      mask_ff <= nxt_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read data, registered; unmapped offsets answer zero
  always_comb begin
    nxt_rdata = '0;
    if (reg_rd) begin
      if (hit(reg_addr, OFF_TOP_STAT)) begin
        nxt_rdata[15:0] = top_stat;
      end else if (hit(reg_addr, OFF_IRQ_MASK)) begin
        nxt_rdata[15:0] = mask_ff;
      end else if (hit(reg_addr, OFF_ACPI_MIRROR) ||
                   hit(reg_addr, OFF_ACPI_STAT)) begin
        nxt_rdata[ACPI_N-1:0] = acpi_if.stat;
      end else if (hit(reg_addr, OFF_EXT_REG)) begin
        nxt_rdata = ext_word;
      end else if (hit(reg_addr, OFF_THT_CTRL)) begin
        nxt_rdata[THT_BIT] = tht_bit_ff;
      end else if (hit(reg_addr, OFF_CMD_PORT)) begin
        nxt_rdata[CMD_W-1:0] = cmd_ff;
      end else if (hit(reg_addr, OFF_SRC_EN)) begin
        nxt_rdata[THT_IRQ_EN_BIT] = tht_irq_en_ff;
      end
    end
  end

  // interrupt level: command status bypasses the mask, one cycle late
  // so the output is glitch-free at the cost of a cycle of latency
  always_comb begin
    nxt_irq = |(top_stat & mask_ff) ||
              acpi_if.stat[ACPI_CMD_BIT];
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      irq_ff <= nxt_irq;
    end
  end

  assign reg_rdata = rdata_ff;
  assign system_mgmt_interrupt = irq_ff;

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  cmd_sets_stat_a: assert property (
    cmd_wr |=> acpi_if.stat[ACPI_CMD_BIT])
    else $error("command write did not set status bit 0");

  cmd_irq_unmasked_a: assert property (
    cmd_wr |=> ##1 system_mgmt_interrupt)
    else $error("command write did not raise the interrupt");

  tht_sets_stat_a: assert property (
    (tht_wr1 && tht_irq_en_ff) |=> acpi_if.stat[ACPI_THT_BIT])
    else $error("throttle write did not set status");

  tht_gated_a: assert property (
    (tht_wr1 && !tht_irq_en_ff && !acpi_if.stat[ACPI_THT_BIT])
    |=> !acpi_if.stat[ACPI_THT_BIT])
    else $error("disabled throttle source set status");

  ext_rst_vals_a: assert property (disable iff (1'b0)
    rst |=> (ext_en_ff == 8'h00 && tht_irq_en_ff))
    else $error("wrong reset value");

  ext_gate_a: assert property (
    1'b1 |=> ((ext_if.stat & ~$past(ext_if.stat) &
              ~$past(ext_int_in & ext_en_ff)) == '0))
    else $error("external status set without an enabled input");

  ext_capture_a: assert property (
    (ext_int_in & ext_en_ff) != '0 |=>
    ((ext_if.stat & $past(ext_int_in & ext_en_ff)) ==
     $past(ext_int_in & ext_en_ff)))
    else $error("enabled external input not recorded");

  ext_read_clr_a: assert property (
    (reg_rd && hit(reg_addr, OFF_EXT_REG) &&
     (ext_int_in & ext_en_ff) == '0) |=> (ext_if.stat == '0))
    else $error("reading external status did not clear it");

  ext_mirror_a: assert property (
    (reg_rd && hit(reg_addr, OFF_EXT_REG)) |=>
    (reg_rdata[15:8] == reg_rdata[23:16] && reg_rdata[31:24] == '0))
    else $error("mirror field differs from status field");

  top_summary_a: assert property (
    (ext_summary && mask_ff[TOP_EXT_BIT]) |=> system_mgmt_interrupt)
    else $error("external summary did not reach the interrupt");

  ////////////////////////////////////////////////////////////////////
  // register side checks: the read port idles at zero so a stale word
  // can never be mistaken for a fresh answer
  rdata_idle_a: assert property (
    !reg_rd |=> (reg_rdata == '0))
    else $error("read data not zero outside a read answer");

  ext_rd_data_a: assert property (
    (reg_rd && hit(reg_addr, OFF_EXT_REG)) |=>
    (reg_rdata[23:16] == $past(ext_if.stat) &&
     reg_rdata[7:0] == $past(ext_en_ff)))
    else $error("external register read returned wrong fields");

  ext_en_write_a: assert property (
    (reg_wr && hit(reg_addr, OFF_EXT_REG)) |=>
    (ext_en_ff == $past(reg_wdata[EXT_EN_LSB +: EXT_N])))
    else $error("external enables not written");

  src_en_write_a: assert property (
    (reg_wr && hit(reg_addr, OFF_SRC_EN)) |=>
    (tht_irq_en_ff == $past(reg_wdata[THT_IRQ_EN_BIT])))
    else $error("throttle source enable not written");

  top_rd_keep_a: assert property (
    (reg_rd && hit(reg_addr, OFF_TOP_STAT)) |=>
    ((ext_if.stat & $past(ext_if.stat)) == $past(ext_if.stat)))
    else $error("reading top status cleared external status");

  ext_sum_hold_a: assert property (
    (ext_summary && !(reg_rd && hit(reg_addr, OFF_EXT_REG)) &&
     !(reg_wr && hit(reg_addr, OFF_EXT_REG))) |=> ext_summary)
    else $error("external summary dropped while status pending");

  ////////////////////////////////////////////////////////////////////
  // firmware-interface sources: each status bit has exactly one cause
  cmd_only_a: assert property (
    (!cmd_wr && !acpi_if.stat[ACPI_CMD_BIT]) |=>
    !acpi_if.stat[ACPI_CMD_BIT])
    else $error("command status set without a command write");

  tht_only_a: assert property (
    (!tht_wr1 && !acpi_if.stat[ACPI_THT_BIT]) |=>
    !acpi_if.stat[ACPI_THT_BIT])
    else $error("throttle status set without a throttle write");

  cmd_no_mask_a: assert property (
    acpi_if.stat[ACPI_CMD_BIT] |=> system_mgmt_interrupt)
    else $error("pending command status did not hold the interrupt");

  acpi_rd_clr_a: assert property (
    (reg_rd && hit(reg_addr, OFF_ACPI_STAT) && !cmd_wr && !tht_wr1)
    |=> (acpi_if.stat == '0))
    else $error("reading source status did not clear it");

endmodule

// File: dv/esl_src_model.sv
// model of the external interrupt sources outside the core logic.
// assumes the bench pulses fire for one cycle; lines then stay up for
// HOLD cycles and fall back to the idle low level.
module esl_src_model
  import esl_pkg::*;
#(
  parameter int HOLD = 2
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [EXT_N-1:0] fire,
  output logic [EXT_N-1:0] ext_int_in
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;

  //////////////////////////////////////////////////////////////////////
  // level sources: holding more than one cycle shows that a level
  // re-sets status without making extra events visible to software
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt <= 0;
      ext_int_in <= 8'h00;
    end else if (|fire) begin
      cnt <= HOLD;
      ext_int_in <= fire;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else begin
      cnt <= 0;
      ext_int_in <= 8'h00; // released lines go back to idle low
    end
  end
endmodule

// File: dv/test_external_smi_status_logic.sv
// self-checking bench for the external interrupt status logic.
// assumes the register port answers reads one cycle after the strobe.
module test_external_smi_status_logic
  import esl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk;
  logic rst;
  logic reg_wr;
  logic reg_rd;
  logic system_mgmt_interrupt;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic [DATA_W-1:0] reg_rdata;
  logic [EXT_N-1:0] ext_int_in;
  logic [EXT_N-1:0] fire;
  int fails;
  int check_count;

  esl_top DUT (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ext_int_in(ext_int_in),
    .system_mgmt_interrupt(system_mgmt_interrupt));
  esl_src_model #(.HOLD(2)) SRC (.sys_clk(sys_clk), .rst(rst),
    .fire(fire), .ext_int_in(ext_int_in));

  //////////////////////////////////////////////////////////////////////
  // 10 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  //////////////////////////////////////////////////////////////////////
  // bus and compare tasks
  task automatic chk(input logic [DATA_W-1:0] got,
                     input logic [DATA_W-1:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so look there
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
    // one cycle later the port must be back at its idle zero
    @(posedge sys_clk);
    #1 chk(reg_rdata, 32'h0);
  endtask

  // the interrupt lags its cause by two edges
  task automatic irq(input logic exp);
    repeat (2) @(posedge sys_clk);
    #1 chk(32'(system_mgmt_interrupt), 32'(exp));
  endtask

  task automatic pulse(input logic [EXT_N-1:0] v);
    @(posedge sys_clk);
    fire <= v;
    @(posedge sys_clk);
    fire <= 8'h00;
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic final_report;
    $display("errors %0d checks %0d", fails, check_count);
    if (fails == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    fire = 8'h00;
    fails = 0;
    check_count = 0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    rd(OFF_EXT_REG, 32'h0);
    rd(OFF_SRC_EN, 32'h0000_0100);
    rd(9'h1fe, 32'h0);
    irq(1'b0);
    wr(OFF_EXT_REG, 32'h0000_00a5);
    rd(OFF_EXT_REG, 32'h0000_00a5);
    // every input fires, only the enabled one may be recorded
    for (int n = 0; n < EXT_N; n++) begin
      wr(OFF_EXT_REG, 32'h1 << n);
      pulse(8'hff);
      rd(OFF_TOP_STAT, 32'h0000_0400);
      irq(1'b1);
      rd(OFF_EXT_REG, 32'h0001_0101 << n);
      rd(OFF_EXT_REG, 32'h1 << n);
      irq(1'b0);
    end
    // summary masked, then unmasked while status still pending
    wr(OFF_IRQ_MASK, 32'h0);
    wr(OFF_EXT_REG, 32'h0000_00ff);
    pulse(8'h0f);
    irq(1'b0);
    rd(OFF_TOP_STAT, 32'h0000_0400);
    wr(OFF_IRQ_MASK, 32'h0000_0404);
    irq(1'b1);
    rd(OFF_EXT_REG, 32'h000f_0fff);
    irq(1'b0);
    // command port cannot be masked
    wr(OFF_IRQ_MASK, 32'h0);
    wr(OFF_CMD_PORT, 32'h0000_005a);
    irq(1'b1);
    rd(OFF_ACPI_MIRROR, 32'h1);
    rd(OFF_ACPI_STAT, 32'h1);
    irq(1'b0);
    // throttle write, first with its source disabled
    wr(OFF_IRQ_MASK, 32'h0000_0404);
    wr(OFF_SRC_EN, 32'h0);
    wr(OFF_THT_CTRL, 32'h10);
    rd(OFF_ACPI_MIRROR, 32'h0);
    irq(1'b0);
    wr(OFF_SRC_EN, 32'h0000_0100);
    wr(OFF_THT_CTRL, 32'h10);
    irq(1'b1);
    rd(OFF_ACPI_STAT, 32'h2);
    rd(OFF_THT_CTRL, 32'h10);
    irq(1'b0);
    final_report;
  end

  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge sys_clk);
    fails++;
    final_report;
  end
endmodule
